// >>> hw/tspc_top.sv
`timescale 1ns/1ps
`include "tspc_consts.svh"
// Overview of operation
// - Selector 00b binds level/pulse use to target pair 0, 01b to pair 1.
// - In pulse use the selected pair is leading edge, the other trailing edge.
// - Pin toggles at leading target, returns to previous level at trailing target.
// - At most two output clocks, each synchronized to system time.
// - Selector 10b drives a clock from pair 0, 11b from pair 1.
// - Clock pin drives zero until system time reaches the target.
// - Then endlessly add half cycle to target and toggle on reaching it.
// - Input pin transition copies system time into the aux capture pair.
// - Capture sets its cause flag; interrupt only if unmasked and enabled.
// - High-word read re-arms the pair; no capture before that read.
// - Cause register records each cause; mask register gates each bit.
// - Any asserted time sync interrupt sets the main summary bit.
// - System time advances each 8 ns time tick; compares use current value.
// - Target pairs share the seconds/nanoseconds layout of system time.
module tspc_top
  import tspc_pkg::*;
#(
  parameter int NUM_PINS = 4,
  parameter int NUM_TGT = 2
)
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_time_tick,
  input wire tspc_time_s i_time_load,
  input wire logic i_time_load_stb,
  input wire tspc_pin_cfg_s [3:0] i_pin_cfg,
  input wire logic [3:0] i_pin_in,
  input wire tspc_time_s [1:0] i_target,
  input wire logic [1:0] i_target_wr,
  input wire logic [1:0] i_target_enable,
  input wire logic [1:0] i_pulse_mode,
  input wire logic [1:0] i_clk_out_enable,
  input wire logic [31:0] i_half_period0,
  input wire logic [31:0] i_half_period1,
  input wire tspc_aux_cfg_s [1:0] i_aux_cfg,
  input wire logic [1:0] i_aux_high_rd,
  input wire logic [1:0] i_cause_clr,
  input wire logic [1:0] i_cause_mask,
  input wire logic i_ts_int_enable,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  output tspc_time_s o_system_time,
  output tspc_time_s [1:0] o_aux_capture,
  output logic [1:0] o_aux_armed,
  output logic [1:0] o_cause,
  output logic o_main_summary,
  output logic o_irq,
  output logic [1:0] o_clk_active
);
  // Refuse sizes the fixed pin and target logic cannot serve
  if (NUM_PINS != 4 || NUM_TGT != 2)
  begin : g_size_check
    $error("tspc_top supports exactly four pins and two targets");
  end

  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Three-stage pin synchronisers
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= i_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // System time counter, nanoseconds wrap into seconds
  tspc_time_s now_q;
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      now_q <= '0;
    else if (i_time_load_stb)
      now_q <= i_time_load;
    else if (i_time_tick)
    begin
      if (now_q.ns >= `TSPC_NS_PER_SEC - `TSPC_TICK_NS)
      begin
        now_q.ns <= now_q.ns + `TSPC_TICK_NS - `TSPC_NS_PER_SEC;
        now_q.sec <= now_q.sec + 32'h00000001;
      end
      else
        now_q.ns <= now_q.ns + `TSPC_TICK_NS;
    end
  end

  // Target pairs: software writes, clock mode advances by half period
  tspc_time_s [1:0] tgt_q;
  logic [1:0] ge;
  logic [1:0] ge_q;
  tspc_clk_st_e [1:0] clk_st_q;
  logic [1:0] clk_lvl_q;
  logic [1:0] clk_step;
  // Compare results lag a target write by one cycle, so ignore them then
  logic [1:0] tgt_wr_q;
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tgt_wr_q <= 2'h0;
    else
      tgt_wr_q <= i_target_wr;
  end
  logic [31:0] half [1:0];
  assign half[0] = i_half_period0;
  assign half[1] = i_half_period1;

  genvar gt;
  generate
    for (gt = 0; gt < 2; gt++)
    begin : g_tgt
      tspc_time_cmp u_cmp (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_now(now_q),
        .i_tgt(tgt_q[gt]),
        .o_ge(ge[gt])
      );

      logic [31:0] ns_sum;
      assign ns_sum = {2'b00, tgt_q[gt].ns} + half[gt];

      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          tgt_q[gt] <= '0;
        else if (i_target_wr[gt])
          tgt_q[gt] <= i_target[gt];
        else if (clk_step[gt])
        begin
          if (ns_sum >= {2'b00, `TSPC_NS_PER_SEC})
          begin
            tgt_q[gt].ns <= 30'(ns_sum - {2'b00, `TSPC_NS_PER_SEC});
            tgt_q[gt].sec <= tgt_q[gt].sec + 32'h00000001;
          end
          else
            tgt_q[gt].ns <= ns_sum[29:0];
        end
      end

      // Clock state: wait for start, then toggle each time target is passed
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          clk_st_q[gt] <= TSPC_CLK_IDLE;
          clk_lvl_q[gt] <= 1'b0;
        end
        else if (!i_clk_out_enable[gt] || i_target_wr[gt])
        begin
          clk_st_q[gt] <= i_clk_out_enable[gt] ? TSPC_CLK_WAIT : TSPC_CLK_IDLE;
          clk_lvl_q[gt] <= 1'b0;
        end
        else
        begin
          case (clk_st_q[gt])
            TSPC_CLK_IDLE: clk_st_q[gt] <= TSPC_CLK_WAIT;
            TSPC_CLK_WAIT:
              if (ge[gt] && !clk_step[gt] && !tgt_wr_q[gt])
                clk_st_q[gt] <= TSPC_CLK_RUN;
            TSPC_CLK_RUN:
              if (ge[gt] && !clk_step[gt] && !tgt_wr_q[gt])
                clk_lvl_q[gt] <= ~clk_lvl_q[gt];
            default: clk_st_q[gt] <= TSPC_CLK_IDLE;
          endcase
        end
      end

      // Pipeline hold: one cycle between target step and next compare result
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          ge_q[gt] <= 1'b0;
        else
          ge_q[gt] <= clk_step[gt];
      end
      assign clk_step[gt] = i_clk_out_enable[gt] && (clk_st_q[gt] != TSPC_CLK_IDLE)
                            && ge[gt] && !ge_q[gt] && !i_target_wr[gt] && !tgt_wr_q[gt];
    end
  endgenerate

  // Level-change events: one per target per arming
  logic [1:0] fired_q;
  logic [1:0] lvl_evt;
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fired_q <= 2'h0;
    else
      for (int t = 0; t < 2; t++)
        if (i_target_wr[t] || !i_target_enable[t])
          fired_q[t] <= 1'b0;
        else if (lvl_evt[t])
          fired_q[t] <= 1'b1;
  end
  assign lvl_evt = ge & i_target_enable & ~fired_q & ~i_clk_out_enable & ~tgt_wr_q;

  // Pin drivers
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_pin
      logic tsel;
      logic lead;
      logic trail;
      assign tsel = i_pin_cfg[gp].sel[0];
      assign lead = lvl_evt[tsel];
      assign trail = lvl_evt[~tsel] && i_pulse_mode[tsel];
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          o_pin_out[gp] <= 1'b0;
          o_pin_oe[gp] <= 1'b0;
        end
        else
        begin
          o_pin_oe[gp] <= i_pin_cfg[gp].out_en;
          if (!i_pin_cfg[gp].out_en)
            o_pin_out[gp] <= 1'b0;
          else if (i_pin_cfg[gp].sel[1])
            o_pin_out[gp] <= clk_lvl_q[tsel];
          else if (lead ^ trail)
            o_pin_out[gp] <= ~o_pin_out[gp];
        end
      end
    end
  endgenerate

  // Auxiliary capture units
  logic [1:0] cap_evt;
  genvar ga;
  generate
    for (ga = 0; ga < 2; ga++)
    begin : g_aux
      logic edge_seen;
      assign edge_seen = pin_s2_q[i_aux_cfg[ga].pin_sel] ^ pin_s3_q[i_aux_cfg[ga].pin_sel];
      assign cap_evt[ga] = i_aux_cfg[ga].cap_en && i_aux_cfg[ga].ts_en && edge_seen
                           && o_aux_armed[ga];
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          o_aux_capture[ga] <= '0;
          o_aux_armed[ga] <= 1'b1;
        end
        else if (cap_evt[ga])
        begin
          o_aux_capture[ga] <= now_q;
          o_aux_armed[ga] <= 1'b0;
        end
        else if (i_aux_high_rd[ga])
          o_aux_armed[ga] <= 1'b1;
      end
    end
  endgenerate

  // Cause flags: set wins over clear
  logic [1:0] irq_pend;
  assign irq_pend = (o_cause | cap_evt) & i_cause_mask;
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_cause <= 2'h0;
      o_irq <= 1'b0;
      o_main_summary <= 1'b0;
      o_system_time <= '0;
      o_clk_active <= 2'h0;
    end
    else
    begin
      o_cause <= (o_cause & ~i_cause_clr) | cap_evt;
      o_irq <= |irq_pend && i_ts_int_enable;
      o_main_summary <= |irq_pend;
      o_system_time <= now_q;
      for (int c = 0; c < 2; c++)
        o_clk_active[c] <= (clk_st_q[c] == TSPC_CLK_RUN);
    end
  end
endmodule

// >>> hw/tspc_consts.svh
`ifndef TSPC_CONSTS_SVH
`define TSPC_CONSTS_SVH
`define TSPC_NS_W 30
`define TSPC_SEC_W 32
`define TSPC_NS_PER_SEC 30'h3B9ACA00
`define TSPC_TICK_NS 30'h00000008
`define TSPC_SYS_CLK_MHZ 200
`define TSPC_TIME_CLK_MHZ 125
`define TSPC_HALF_MAX_NS 32'h042C1D80
`define TSPC_HALF_125MS 32'h07735940
`define TSPC_HALF_250MS 32'h0EE6B280
`define TSPC_HALF_500MS 32'h1DCD6500
`define TSPC_SEL_LVL0 2'h0
`define TSPC_SEL_LVL1 2'h1
`define TSPC_SEL_CLK0 2'h2
`define TSPC_SEL_CLK1 2'h3
`define TSPC_CAUSE_AUX0 0
`define TSPC_CAUSE_AUX1 1
`endif

// >>> hw/tspc_pkg.sv
package tspc_pkg;
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } tspc_time_s;
  typedef struct packed {
    logic out_en;
    logic [1:0] sel;
  } tspc_pin_cfg_s;
  typedef struct packed {
    logic cap_en;
    logic [1:0] pin_sel;
    logic ts_en;
  } tspc_aux_cfg_s;
  typedef enum logic [1:0] {
    TSPC_CLK_IDLE = 2'b00,
    TSPC_CLK_WAIT = 2'b01,
    TSPC_CLK_RUN = 2'b10
  } tspc_clk_st_e;
endpackage

// >>> hw/tspc_time_cmp.sv
`timescale 1ns/1ps
`include "tspc_consts.svh"
module tspc_time_cmp
  import tspc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire tspc_time_s i_now,
  input wire tspc_time_s i_tgt,
  output logic o_ge
);
  // Seconds dominate, nanoseconds break ties; registered result
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ge <= 1'b0;
    else
      o_ge <= ({i_now.sec, i_now.ns} >= {i_tgt.sec, i_tgt.ns});
  end
endmodule

// >>> tb/tspc_pin_model.sv
`timescale 1ns/1ps
module tspc_pin_model
(
  input wire logic i_clk,
  input wire logic [3:0] i_pin_out,
  input wire logic [3:0] i_pin_oe,
  input wire logic [3:0] i_flip,
  output logic [3:0] o_pin_in
);
  logic [3:0] ext_q = 4'h0;
  // Outside source flips a line on request, just after the edge
  always @(posedge i_clk) ext_q <= #1 ext_q ^ i_flip;
  // Device wins the wire while it drives
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_q);
endmodule

// >>> tb/tspc_top_asserts.sv
`timescale 1ns/1ps
module tspc_top_asserts
  import tspc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_time_tick,
  input wire logic i_time_load_stb,
  input wire logic [1:0] i_target_enable,
  input wire logic [1:0] i_clk_out_enable,
  input wire logic [1:0] i_aux_high_rd,
  input wire logic [1:0] i_cause_mask,
  input wire logic i_ts_int_enable,
  input wire logic [3:0] o_pin_out,
  input wire tspc_time_s o_system_time,
  input wire tspc_time_s [1:0] o_aux_capture,
  input wire logic [1:0] o_aux_armed,
  input wire logic [1:0] o_cause,
  input wire logic o_main_summary,
  input wire logic o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence cap0_s;
    $changed(o_aux_capture[0]);
  endsequence
  time_hold_a: assert property ((!i_time_tick && !i_time_load_stb) [*3]
    |=> $stable(o_system_time)) else $error("time moved without tick");
  cap_hold_a: assert property (!o_aux_armed[0] && !i_aux_high_rd[0]
    |=> $stable(o_aux_capture[0])) else $error("capture while disarmed");
  cap_disarm_a: assert property (cap0_s |-> ##[0:1] !o_aux_armed[0])
    else $error("capture left armed");
  cap_cause_a: assert property (cap0_s |-> ##[0:2] o_cause[0])
    else $error("capture without cause");
  summary_mask_a: assert property (((o_cause & i_cause_mask) == 2'h0) [*2]
    |-> !o_main_summary) else $error("summary from masked cause");
  irq_gate_a: assert property ((!i_ts_int_enable) [*2] |-> !o_irq)
    else $error("irq while disabled");
  irq_summary_a: assert property ($rose(o_irq)
    |-> o_main_summary || $past(o_main_summary)) else $error("irq without summary");
  pin_quiet_a: assert property ((i_target_enable == 2'h0 && i_clk_out_enable == 2'h0) [*4]
    |=> $stable(o_pin_out)) else $error("pin moved with no event");
endmodule
bind tspc_top tspc_top_asserts i_chk (.i_sys_clk, .i_nrst, .i_time_tick, .i_time_load_stb,
  .i_target_enable, .i_clk_out_enable, .i_aux_high_rd, .i_cause_mask, .i_ts_int_enable,
  .o_pin_out, .o_system_time, .o_aux_capture, .o_aux_armed, .o_cause, .o_main_summary,
  .o_irq);

// >>> tb/tspc_top_test.sv
`timescale 1ns/1ps
module tspc_top_test
  import tspc_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_nrst, i_time_tick, i_time_load_stb, i_ts_int_enable, o_main_summary, o_irq;
  tspc_time_s i_time_load, o_system_time;
  tspc_pin_cfg_s [3:0] i_pin_cfg;
  tspc_time_s [1:0] i_target, o_aux_capture;
  tspc_aux_cfg_s [1:0] i_aux_cfg;
  logic [1:0] i_target_wr, i_target_enable, i_pulse_mode, i_clk_out_enable, i_aux_high_rd;
  logic [1:0] i_cause_clr, i_cause_mask, o_aux_armed, o_cause, o_clk_active;
  logic [31:0] i_half_period0, i_half_period1;
  logic [3:0] o_pin_out, o_pin_oe, i_pin_in, flip;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  tspc_top i_dut (.i_sys_clk, .i_nrst, .i_time_tick, .i_time_load, .i_time_load_stb,
    .i_pin_cfg, .i_pin_in, .i_target, .i_target_wr, .i_target_enable, .i_pulse_mode,
    .i_clk_out_enable, .i_half_period0, .i_half_period1, .i_aux_cfg, .i_aux_high_rd,
    .i_cause_clr, .i_cause_mask, .i_ts_int_enable, .o_pin_out, .o_pin_oe, .o_system_time,
    .o_aux_capture, .o_aux_armed, .o_cause, .o_main_summary, .o_irq, .o_clk_active);
  tspc_pin_model i_far (.i_clk(i_sys_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_flip(flip), .o_pin_in(i_pin_in));
  task results;
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ticks(input int n);
    repeat (n)
    begin
      i_time_tick = 1'b1;
      cyc(1);
      i_time_tick = 1'b0;
      cyc(1);
    end
    cyc(6);
  endtask
  task load(input tspc_time_s t);
    i_time_load = t;
    i_time_load_stb = 1'b1;
    cyc(1);
    i_time_load_stb = 1'b0;
    cyc(3);
  endtask
  task write_tgt(input int j, input tspc_time_s t);
    i_target[j] = t;
    i_target_wr[j] = 1'b1;
    cyc(1);
    i_target_wr[j] = 1'b0;
    cyc(1);
  endtask
  task flip_pin;
    flip = 4'h2;
    cyc(1);
    flip = 4'h0;
    cyc(6);
  endtask
  task test_pulse;
    load({32'h5, 30'h3B9AC9F0});
    ticks(3);
    check(o_system_time, {32'h6, 30'h8});
    i_pin_cfg[0] = {1'b1, 2'h0};
    i_pin_cfg[1] = {1'b1, 2'h1};
    i_pulse_mode = 2'h2;
    write_tgt(1, {32'h6, 30'h10});
    write_tgt(0, {32'h7, 30'h0});
    i_target_enable = 2'h3;
    cyc(6);
    check(o_pin_out[1:0], 2'h0);
    ticks(1);
    check(o_pin_out[1:0], 2'h2);
    load({32'h7, 30'h0});
    cyc(4);
    check(o_pin_out[1:0], 2'h1);
    i_target_enable = 2'h0;
  endtask
  task test_clock;
    load({32'h0, 30'h0});
    i_half_period0 = 32'h10;
    i_half_period1 = 32'h18;
    for (int j = 0; j < 2; j++)
    begin
      i_pin_cfg[2 + j] = {2'h3, j[0]};
      i_clk_out_enable[j] = 1'b1;
      write_tgt(j, {32'h0, 30'h20});
    end
    ticks(3);
    check(o_pin_out[3:2], 2'h0);
    ticks(1);
    check(o_pin_out[3:2], 2'h0);
    ticks(2);
    check(o_pin_out[3:2], 2'h1);
    ticks(1);
    check(o_pin_out[3:2], 2'h3);
    ticks(1);
    check(o_pin_out[3:2], 2'h2);
    check(o_clk_active, 2'h3);
    i_clk_out_enable = 2'h0;
  endtask
  task test_capture;
    load({32'h12, 30'h40});
    i_pin_cfg[1] = {1'b0, 2'h1};
    i_aux_cfg[0] = {1'b1, 2'h1, 1'b1};
    i_cause_mask = 2'h1;
    i_ts_int_enable = 1'b1;
    cyc(2);
    flip_pin;
    check(o_aux_capture[0], {32'h12, 30'h40});
    check({o_cause, o_main_summary, o_irq}, 4'h7);
    check(o_aux_armed, 2'h2);
    ticks(1);
    flip_pin;
    check(o_aux_capture[0], {32'h12, 30'h40});
    i_aux_high_rd[0] = 1'b1;
    cyc(1);
    i_aux_high_rd[0] = 1'b0;
    i_cause_clr = 2'h1;
    cyc(1);
    i_cause_clr = 2'h0;
    i_cause_mask = 2'h0;
    cyc(2);
    check({o_cause, o_main_summary, o_irq}, 4'h0);
    check(o_aux_armed, 2'h3);
    check(o_pin_oe, 4'hD);
    flip_pin;
    check(o_aux_capture[0], {32'h12, 30'h48});
    check({o_cause, o_main_summary, o_irq}, 4'h4);
  endtask
  initial
  begin
    {i_nrst, i_time_tick, i_time_load, i_time_load_stb, i_pin_cfg, i_target, i_target_wr,
      i_target_enable, i_pulse_mode, i_clk_out_enable, i_half_period0, i_half_period1,
      i_aux_cfg, i_aux_high_rd, i_cause_clr, i_cause_mask, i_ts_int_enable, flip} = '0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    cyc(3);
    check({o_aux_armed, o_cause, o_pin_out, o_irq}, 9'h180);
    test_pulse;
    test_clock;
    test_capture;
    results();
  end
endmodule
